// ---- include/adi_params.svh ----
// Constants shared by both ends of the audio DAC control link.
`ifndef ADI_PARAMS_SVH
`define ADI_PARAMS_SVH

`define ADI_ADDR_HI      5'h13
`define ADI_REG_FIRST    7'h10
`define ADI_REG_LAST     7'h16
`define ADI_IDX_RST      7'h00
`define ADI_BYTE_BITS    4'h8
`define ADI_CLK_MHZ      250
`define ADI_SPIKE_NS     50
`define ADI_SPIKE_CYC    ((`ADI_SPIKE_NS * `ADI_CLK_MHZ) / 1000)
`define ADI_SCL_KHZ      400
`define ADI_QTR_CYC      ((`ADI_CLK_MHZ * 1000 + 4 * `ADI_SCL_KHZ - 1) / (4 * `ADI_SCL_KHZ))

`endif

// ---- include/adi_pkg.sv ----
// Types and decode helpers for the audio DAC control link.
package adi_pkg;
`include "adi_params.svh"

	typedef enum logic [6:0] {
		ADI_D_IDLE  = 7'h01,
		ADI_D_ADDR  = 7'h02,
		ADI_D_SACK  = 7'h04,
		ADI_D_REG   = 7'h08,
		ADI_D_WDATA = 7'h10,
		ADI_D_RDATA = 7'h20,
		ADI_D_MACK  = 7'h40
	} adi_dev_st_t;

	typedef enum logic [3:0] {
		ADI_H_IDLE  = 4'h1,
		ADI_H_START = 4'h2,
		ADI_H_BIT   = 4'h4,
		ADI_H_STOP  = 4'h8
	} adi_host_st_t;

	typedef struct packed {
		logic [2:0][4:0] sync;
		logic [4:0]      pin;
		logic [1:0]      line;
		logic [1:0][3:0] fcnt;
		adi_dev_st_t     st;
		adi_dev_st_t     nxt;
		logic [3:0]      cnt;
		logic [7:0]      sh;
		logic [6:0]      idx;
		logic            wrote;
		logic            wr;
		logic [7:0]      wdata;
		logic            oe;
	} adi_dev_state_t;

	typedef struct packed {
		adi_host_st_t st;
		logic [7:0]   tcnt;
		logic [1:0]   ph;
		logic [1:0]   bi;
		logic [3:0]   bc;
		logic [2:0]   sync;
		logic         sdain;
		logic         rd;
		logic [6:0]   dev;
		logic [6:0]   regi;
		logic [7:0]   wdata;
		logic [7:0]   rx;
		logic         ackbit;
		logic [7:0]   rdata;
		logic         done;
		logic         nack;
	} adi_host_state_t;

	function automatic logic adi_reg_defined(input logic [6:0] idx);
		adi_reg_defined = (idx >= `ADI_REG_FIRST) && (idx <= `ADI_REG_LAST);
	endfunction

endpackage

// ---- include/adi_i2c_if.sv ----
// Two-wire control link with wired-AND resolution of the data line; the host alone drives the clock.
`timescale 1ns/1ps
interface adi_i2c_if;
	logic scl_m_o;
	logic scl_m_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	logic scl;
	logic sda;

	assign scl = scl_m_oe ? scl_m_o : 1'b1;
	assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

	modport dev (
		input  scl,
		input  sda,
		output sda_s_o,
		output sda_s_oe
	);

	modport host (
		input  scl,
		input  sda,
		output scl_m_o,
		output scl_m_oe,
		output sda_m_o,
		output sda_m_oe
	);
endinterface // adi_i2c_if

// ---- core/adi_dev.sv ----
// Device end: two-wire slave port giving access to the DAC mode registers.
// Operation
// R1 - Master writes address, register byte, data bytes.
// R2 - Register byte names first register written.
// R3 - Index increments after each received data byte.
// R4 - Index wraps from top value to zero.
// R5 - Undefined register access gets no acknowledge.
// R6 - Master loads index by write before reading.
// R7 - Master then sends address with read bit.
// R8 - Read returns register selected by index.
// R9 - Index increments after each byte read.
// R10 - First read after write keeps last written index.
// R11 - Upper sixteen indexes always return some byte.
// R12 - Glitch filter runs on the system clock.
// R13 - Filter copes with two spikes per window.
// R14 - Spikes up to fifty nanoseconds are suppressed.
// R15 - Slow clock may misread high data bits.
// R16 - Slow clock may miss a start condition.
// R17 - Fast clock with wide spikes: false start/stop.
// R18 - Address is fixed five bits plus select pins.
// R19 - Port active only while select pin high.
// R20 - Device never drives clock nor starts frames.
// R21 - Master ends read with NACK then stop.
// R22 - Acknowledge own address and defined register bytes.
`timescale 1ns/1ps
`include "adi_params.svh"
module adi_dev
	import adi_pkg::*;
(
	input  wire logic         core_clk_i,
	input  wire logic         rst_i,
	input  wire logic         control_port_select_i,
	input  wire logic         addr_select_bit0_i,
	input  wire logic         addr_select_bit1_i,
	adi_i2c_if.dev            bus,
	output logic      [6:0]   reg_idx_o,
	output logic              reg_wr_o,
	output logic      [7:0]   reg_wdata_o,
	input  wire logic [7:0]   reg_rdata_i
);
	import adi_pkg::*;

	localparam logic [3:0] SPIKE_LIM = 4'(`ADI_SPIKE_CYC + 1);

	adi_dev_state_t q;
	adi_dev_state_t d;

	// A level only reaches the filter once the second and third stages agree,
	// so metastability on the first stage never reaches the protocol logic.
	always_comb
	begin
		logic scl_rise;
		logic scl_fall;
		logic start_ev;
		logic stop_ev;
		logic [6:0] own_addr;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		start_ev = 1'b0;
		stop_ev  = 1'b0;
		own_addr = 7'h00;
		d = q;
		d.wr = 1'b0;
		d.sync[0] = {addr_select_bit1_i, addr_select_bit0_i, control_port_select_i,
			bus.sda, bus.scl};
		d.sync[1] = q.sync[0];
		d.sync[2] = q.sync[1];
		for (int i = 0; i < 5; i++)
		begin
			if (q.sync[1][i] == q.sync[2][i])
			begin
				d.pin[i] = q.sync[2][i];
			end
		end
		// A new level must persist longer than the widest spike to be taken.
		// At this clock rate the slow-clock failure cases cannot arise; wide
		// spikes on both lines around a clock fall can still fake a frame edge.
		for (int i = 0; i < 2; i++)
		begin
			if (q.pin[i] == q.line[i])
			begin
				d.fcnt[i] = 4'h0;
			end
			else if (q.fcnt[i] == SPIKE_LIM)
			begin
				d.line[i] = q.pin[i]; // see R12 see R13 see R14 see R15 see R16 see R17
				d.fcnt[i] = 4'h0;
			end
			else
			begin
				d.fcnt[i] = q.fcnt[i] + 4'h1;
			end
		end
		scl_rise = ~q.line[0] & d.line[0];
		scl_fall = q.line[0] & ~d.line[0];
		start_ev = q.line[0] & d.line[0] & q.line[1] & ~d.line[1];
		stop_ev  = q.line[0] & d.line[0] & ~q.line[1] & d.line[1];
		own_addr = {`ADI_ADDR_HI, q.pin[4], q.pin[3]}; // see R18

		if (!q.pin[2])
		begin
			d.st = ADI_D_IDLE; // see R19
		end
		else if (start_ev)
		begin
			d.st = ADI_D_ADDR;
			d.cnt = 4'h0;
		end
		else if (stop_ev)
		begin
			d.st = ADI_D_IDLE;
		end
		else if (scl_rise)
		begin
			unique case (q.st)
				ADI_D_ADDR, ADI_D_REG, ADI_D_WDATA:
				begin
					d.sh = {q.sh[6:0], q.line[1]}; // see R1
					d.cnt = q.cnt + 4'h1;
				end
				ADI_D_RDATA:
				begin
					d.cnt = q.cnt + 4'h1;
				end
				ADI_D_MACK:
				begin
					if (q.line[1])
					begin
						d.st = ADI_D_IDLE; // see R21
					end
					else
					begin
						d.idx = q.idx + 7'h01; // see R9 see R4
					end
				end
				ADI_D_IDLE, ADI_D_SACK:
				begin
				end
			endcase
		end
		else if (scl_fall)
		begin
			unique case (q.st)
				ADI_D_ADDR:
				begin
					if (q.cnt == `ADI_BYTE_BITS)
					begin
						if (q.sh[7:1] == own_addr)
						begin
							d.st = ADI_D_SACK; // see R22
							d.nxt = q.sh[0] ? ADI_D_RDATA : ADI_D_REG;
							d.wrote = 1'b0;
							if (q.sh[0] && q.wrote)
							begin
								// Undo the post-write step so the last written
								// register is the first one returned.
								d.idx = q.idx - 7'h01; // see R10 see R7
							end
						end
						else
						begin
							d.st = ADI_D_IDLE;
						end
					end
				end
				ADI_D_REG:
				begin
					if (q.cnt == `ADI_BYTE_BITS)
					begin
						d.idx = q.sh[6:0]; // see R2 see R6
						d.wrote = 1'b0;
						if (adi_reg_defined(q.sh[6:0]))
						begin
							d.st = ADI_D_SACK; // see R22
							d.nxt = ADI_D_WDATA;
						end
						else
						begin
							d.st = ADI_D_IDLE; // see R5
						end
					end
				end
				ADI_D_WDATA:
				begin
					if (q.cnt == `ADI_BYTE_BITS)
					begin
						if (adi_reg_defined(q.idx))
						begin
							d.wr = 1'b1;
							d.wdata = q.sh;
							d.idx = q.idx + 7'h01; // see R3 see R4 see R2
							d.wrote = 1'b1;
							d.st = ADI_D_SACK; // see R22
							d.nxt = ADI_D_WDATA;
						end
						else
						begin
							d.st = ADI_D_IDLE; // see R5
						end
					end
				end
				ADI_D_SACK:
				begin
					d.cnt = 4'h0;
					d.st = q.nxt;
					if (q.nxt == ADI_D_RDATA)
					begin
						// Any index yields a byte, defined or not.
						d.sh = reg_rdata_i; // see R8 see R11
					end
				end
				ADI_D_RDATA:
				begin
					if (q.cnt == `ADI_BYTE_BITS)
					begin
						d.st = ADI_D_MACK;
					end
					else
					begin
						d.sh = {q.sh[6:0], 1'b0};
					end
				end
				ADI_D_MACK:
				begin
					d.st = ADI_D_RDATA;
					d.cnt = 4'h0;
					d.sh = reg_rdata_i; // see R8 see R9
				end
				ADI_D_IDLE:
				begin
				end
			endcase
		end
		// Only the data line is ever pulled; the clock is never driven.
		d.oe = (d.st == ADI_D_SACK) || ((d.st == ADI_D_RDATA) && !d.sh[7]); // see R20
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			q <= '{sync: '1, pin: 5'h03, line: 2'h3, fcnt: '0, st: ADI_D_IDLE,
				nxt: ADI_D_IDLE, cnt: 4'h0, sh: 8'h00, idx: `ADI_IDX_RST,
				wrote: 1'b0, wr: 1'b0, wdata: 8'h00, oe: 1'b0};
		end
		else
		begin
			q <= d;
		end
	end

	assign bus.sda_s_o  = 1'b0;
	assign bus.sda_s_oe = q.oe;
	assign reg_idx_o    = q.idx;
	assign reg_wr_o     = q.wr;
	assign reg_wdata_o  = q.wdata;

endmodule // adi_dev

// ---- core/adi_host.sv ----
// Host end: two-wire master issuing single-byte register writes and reads.
`timescale 1ns/1ps
`include "adi_params.svh"
module adi_host
	import adi_pkg::*;
(
	input  wire logic         core_clk_i,
	input  wire logic         rst_i,
	adi_i2c_if.host           bus,
	input  wire logic         op_valid_i,
	output logic              op_ready_o,
	input  wire logic         op_read_i,
	input  wire logic [6:0]   op_dev_i,
	input  wire logic [6:0]   op_reg_i,
	input  wire logic [7:0]   op_wdata_i,
	output logic              done_o,
	output logic              nack_o,
	output logic      [7:0]   rdata_o
);
	import adi_pkg::*;

	localparam logic [7:0] QTR_LAST = 8'(`ADI_QTR_CYC - 1);

	adi_host_state_t q;
	adi_host_state_t d;
	logic [7:0]      txb;

	always_comb
	begin
		unique case (q.bi)
			2'h0: txb = {q.dev, 1'b0};
			2'h1: txb = {1'b0, q.regi}; // see R1 see R6
			2'h2: txb = q.rd ? {q.dev, 1'b1} : q.wdata; // see R7
			default: txb = 8'hff;
		endcase
	end

	// Each bit is four quarter periods: set data, raise clock, sample, drop clock.
	always_comb
	begin
		logic tick;
		tick = (q.tcnt == QTR_LAST);
		d = q;
		d.done = 1'b0;
		d.sync = {q.sync[1:0], bus.sda};
		if (q.sync[1] == q.sync[2])
		begin
			d.sdain = q.sync[2];
		end
		d.tcnt = (tick || q.st == ADI_H_IDLE) ? 8'h00 : q.tcnt + 8'h01;
		unique case (q.st)
			ADI_H_IDLE:
			begin
				if (op_valid_i)
				begin
					d.st = ADI_H_START;
					d.rd = op_read_i;
					d.dev = op_dev_i;
					d.regi = op_reg_i;
					d.wdata = op_wdata_i;
					d.bi = 2'h0;
					d.ph = 2'h0;
					d.nack = 1'b0;
				end
			end
			ADI_H_START:
			begin
				if (tick)
				begin
					d.ph = q.ph + 2'h1;
					d.bc = 4'h0;
					if (q.ph == 2'h3)
					begin
						d.st = ADI_H_BIT;
					end
				end
			end
			ADI_H_BIT:
			begin
				if (tick)
				begin
					d.ph = q.ph + 2'h1;
					if (q.ph == 2'h2)
					begin
						if (q.bc != `ADI_BYTE_BITS)
						begin
							d.rx = {q.rx[6:0], q.sdain};
						end
						else
						begin
							d.ackbit = q.sdain;
						end
					end
					else if (q.ph == 2'h3)
					begin
						d.bc = q.bc + 4'h1;
						if (q.bc == `ADI_BYTE_BITS)
						begin
							d.bc = 4'h0;
							if (q.bi != 2'h3 && q.ackbit)
							begin
								d.nack = 1'b1;
								d.st = ADI_H_STOP;
							end
							else if (q.bi == 2'h1 && q.rd)
							begin
								d.bi = 2'h2;
								d.st = ADI_H_START; // see R6 see R7
							end
							else if (q.bi == 2'h3 || (q.bi == 2'h2 && !q.rd))
							begin
								d.rdata = q.rd ? q.rx : q.rdata;
								d.st = ADI_H_STOP; // see R21
							end
							else
							begin
								d.bi = q.bi + 2'h1;
							end
						end
					end
				end
			end
			ADI_H_STOP:
			begin
				if (tick)
				begin
					d.ph = q.ph + 2'h1;
					if (q.ph == 2'h3)
					begin
						d.st = ADI_H_IDLE;
						d.done = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			q <= '{st: ADI_H_IDLE, tcnt: 8'h00, ph: 2'h0, bi: 2'h0, bc: 4'h0,
				sync: 3'h7, sdain: 1'b1, rd: 1'b0, dev: 7'h00, regi: 7'h00,
				wdata: 8'h00, rx: 8'h00, ackbit: 1'b1, rdata: 8'h00,
				done: 1'b0, nack: 1'b0};
		end
		else
		begin
			q <= d;
		end
	end

	// The final read byte is answered by releasing the line, a not-acknowledge.
	assign bus.sda_m_oe = ((q.st == ADI_H_START) && q.ph[1])
		|| ((q.st == ADI_H_BIT) && (q.bc != `ADI_BYTE_BITS) && (q.bi != 2'h3)
			&& !txb[~q.bc[2:0]])
		|| ((q.st == ADI_H_STOP) && !q.ph[1]); // see R21
	assign bus.scl_m_oe = (((q.st == ADI_H_START) || (q.st == ADI_H_BIT))
		&& ((q.ph == 2'h0) || (q.ph == 2'h3)))
		|| ((q.st == ADI_H_STOP) && (q.ph == 2'h0));
	assign bus.sda_m_o  = 1'b0;
	assign bus.scl_m_o  = 1'b0;
	assign op_ready_o   = (q.st == ADI_H_IDLE);
	assign done_o       = q.done;
	assign nack_o       = q.nack;
	assign rdata_o      = q.rdata;

endmodule // adi_host

// ---- testbench/adi_chk_sva.sv ----
// Concurrent checks on the control link and the user sides of both ends.
`timescale 1ns/1ps
module adi_chk (
	input wire logic       core_clk_i,
	input wire logic       rst_i,
	input wire logic       scl,
	input wire logic       sda,
	input wire logic       scl_m_o,
	input wire logic       scl_m_oe,
	input wire logic       sda_m_o,
	input wire logic       sda_m_oe,
	input wire logic       sda_s_o,
	input wire logic       sda_s_oe,
	input wire logic       control_port_select_i,
	input wire logic [6:0] reg_idx_o,
	input wire logic       reg_wr_o,
	input wire logic       done_o,
	input wire logic       op_ready_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_wr_pulse;
		reg_wr_o ##1 !reg_wr_o;
	endsequence

	sequence s_ack_soon;
		##[0:60] sda_s_oe;
	endsequence

	od_dev_a: assert property (sda_s_oe |-> !sda_s_o)
		else $error("device drives data line high");
	od_host_a: assert property ((scl_m_oe |-> !scl_m_o) and (sda_m_oe |-> !sda_m_o))
		else $error("host drives a line high");
	dev_scl_low_a: assert property ($changed(sda_s_oe) |-> !scl)
		else $error("device moved data line while clock high");
	wr_pulse_a: assert property ($rose(reg_wr_o) |-> s_wr_pulse)
		else $error("register write strobe longer than one cycle");
	idx_step_a: assert property (reg_wr_o |-> reg_idx_o == 7'($past(reg_idx_o) + 7'h01))
		else $error("index did not advance by one on write");
	wr_defined_a: assert property (reg_wr_o |-> 7'(reg_idx_o - 7'h01) inside {[7'h10:7'h16]})
		else $error("write to undefined register");
	wr_ack_a: assert property (reg_wr_o |-> s_ack_soon)
		else $error("accepted data byte not acknowledged");
	sel_quiet_a: assert property (!control_port_select_i [*8] |-> !sda_s_oe)
		else $error("device drives while port deselected");
	done_pulse_a: assert property (done_o |=> !done_o && op_ready_o)
		else $error("completion pulse not single or host not idle");
endmodule // adi_chk

// ---- testbench/adi_tb.sv ----
// Self-checking bench for both ends of the audio DAC control link.
`timescale 1ns/1ps
module adi_tb;
	import adi_pkg::*;
	localparam logic [6:0] DEV_ADDR = 7'h4e;
	logic       core_clk_i;
	logic       rst_i;
	logic       sel_i;
	logic       addr_sel0;
	logic       addr_sel1;
	logic       op_valid_i;
	logic       op_read_i;
	logic [6:0] op_dev_i;
	logic [6:0] op_reg_i;
	logic [7:0] op_wdata_i;
	logic       op_ready_o;
	logic       done_o;
	logic       nack_o;
	logic [7:0] rdata_o;
	logic [6:0] reg_idx_o;
	logic       reg_wr_o;
	logic [7:0] reg_wdata_o;
	logic [7:0] reg_rdata_i;
	logic [7:0] mem [128];
	int         wr_cnt;
	int         failures;
	int         n_tests;
	int         cyc;

	adi_i2c_if link();

	adi_dev u_adi_dev (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .control_port_select_i(sel_i),
		.addr_select_bit0_i(addr_sel0), .addr_select_bit1_i(addr_sel1), .bus(link.dev),
		.reg_idx_o(reg_idx_o), .reg_wr_o(reg_wr_o), .reg_wdata_o(reg_wdata_o),
		.reg_rdata_i(reg_rdata_i));

	adi_host u_adi_host (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .bus(link.host), .op_valid_i(op_valid_i),
		.op_ready_o(op_ready_o), .op_read_i(op_read_i), .op_dev_i(op_dev_i),
		.op_reg_i(op_reg_i), .op_wdata_i(op_wdata_i), .done_o(done_o), .nack_o(nack_o),
		.rdata_o(rdata_o));

	adi_chk u_chk (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .scl(link.scl), .sda(link.sda),
		.scl_m_o(link.scl_m_o), .scl_m_oe(link.scl_m_oe), .sda_m_o(link.sda_m_o),
		.sda_m_oe(link.sda_m_oe), .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe),
		.control_port_select_i(sel_i), .reg_idx_o(reg_idx_o), .reg_wr_o(reg_wr_o),
		.done_o(done_o), .op_ready_o(op_ready_o));

	assign reg_rdata_i = mem[reg_idx_o];

	initial
	begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end

	// Sampled away from the launching edge so the strobe and index are settled.
	always @(negedge core_clk_i)
	begin
		if (reg_wr_o === 1'b1)
		begin
			mem[reg_idx_o - 7'h01] <= reg_wdata_o;
			wr_cnt++;
		end
		cyc++;
		if (cyc == 99000)
		begin
			failures++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (failures == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			failures++;
		end
	endtask

	// The host runs one whole transfer; the device side is judged after done.
	task automatic run_op(input logic rd, input logic [6:0] dev, input logic [6:0] rg,
		input logic [7:0] wd, input logic exp_nack, input int exp_wr);
		int w0;
		int n;
		w0 = wr_cnt;
		@(negedge core_clk_i);
		op_valid_i = 1'b1;
		op_read_i = rd;
		op_dev_i = dev;
		op_reg_i = rg;
		op_wdata_i = wd;
		while (op_ready_o !== 1'b1)
			@(negedge core_clk_i);
		@(negedge core_clk_i);
		op_valid_i = 1'b0;
		n = 0;
		while (done_o !== 1'b1 && n < 30000)
		begin
			@(negedge core_clk_i);
			n++;
		end
		chk("done", 8'h01, {7'h00, done_o});
		chk("nack", {7'h00, exp_nack}, {7'h00, nack_o});
		chk("write count", 8'(exp_wr), 8'(wr_cnt - w0));
	endtask

	task automatic t_write();
		run_op(1'b0, DEV_ADDR, 7'h16, 8'ha5, 1'b0, 1);
		chk("written data", 8'ha5, mem[7'h16]);
		chk("index after write", 8'h17, {1'b0, reg_idx_o});
	endtask

	task automatic t_read();
		run_op(1'b1, DEV_ADDR, 7'h16, 8'h00, 1'b0, 0);
		chk("read data", 8'ha5, rdata_o);
	endtask

	task automatic t_undef();
		run_op(1'b0, DEV_ADDR, 7'h17, 8'h3c, 1'b1, 0);
	endtask

	task automatic t_addr();
		run_op(1'b0, 7'h4d, 7'h10, 8'h11, 1'b1, 0);
	endtask

	// Other select-pin levels move the answered address; changed only while idle.
	task automatic t_pins();
		@(negedge core_clk_i);
		addr_sel0 = 1'b1;
		addr_sel1 = 1'b0;
		repeat (10) @(negedge core_clk_i);
		run_op(1'b0, 7'h4d, 7'h11, 8'h5a, 1'b0, 1);
		chk("pin address data", 8'h5a, mem[7'h11]);
		addr_sel0 = 1'b0;
		addr_sel1 = 1'b1;
		repeat (10) @(negedge core_clk_i);
	endtask

	// Deselect is applied only while idle so no transfer is cut mid-byte.
	task automatic t_sel();
		@(negedge core_clk_i);
		sel_i = 1'b0;
		repeat (10) @(negedge core_clk_i);
		run_op(1'b0, DEV_ADDR, 7'h10, 8'h22, 1'b1, 0);
		sel_i = 1'b1;
		repeat (20) @(negedge core_clk_i);
	endtask

	initial
	begin
		rst_i = 1'b1;
		sel_i = 1'b1;
		addr_sel0 = 1'b0;
		addr_sel1 = 1'b1;
		op_valid_i = 1'b0;
		op_read_i = 1'b0;
		op_dev_i = 7'h00;
		op_reg_i = 7'h00;
		op_wdata_i = 8'h00;
		wr_cnt = 0;
		failures = 0;
		n_tests = 0;
		cyc = 0;
		for (int i = 0; i < 128; i++)
			mem[i] = 8'(i) ^ 8'hff;
		repeat (12) @(negedge core_clk_i);
		rst_i = 1'b0;
		repeat (12) @(negedge core_clk_i);
		t_write();
		t_read();
		t_undef();
		t_addr();
		t_pins();
		t_sel();
		complete_run();
	end
endmodule // adi_tb
